// File: periodic_timer_pkg.sv
// Constants shared by the periodic timer unit and its bench.
// Assumes a 32-bit AHB-Lite bus with one register per aligned word.
package periodic_timer_pkg;

    // Counter geometry
    localparam int         CNT_W   = 10;
    localparam logic [9:0] VAL_RST = 10'h000;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL0   = 8'h00;
    localparam logic [7:0] OFF_CTRL1   = 8'h04;
    localparam logic [7:0] OFF_CNT_LO  = 8'h08;
    localparam logic [7:0] OFF_CNT_HI  = 8'h0C;
    localparam logic [7:0] OFF_CMPA_LO = 8'h10;
    localparam logic [7:0] OFF_CMPA_HI = 8'h14;
    localparam logic [7:0] OFF_PER_LO  = 8'h18;
    localparam logic [7:0] OFF_PER_HI  = 8'h1C;
    localparam logic [7:0] OFF_FLAGS   = 8'h20;

    // Field positions
    localparam int RUN_POS   = 3;
    localparam int MODE_LSB  = 6;
    localparam int IO_LSB    = 4;
    localparam int OC_POS    = 3;
    localparam int POL_POS   = 2;
    localparam int CAPTS_POS = 1;
    localparam int CCLR_POS  = 0;
    localparam int FLAG_A    = 0;
    localparam int FLAG_P    = 1;

    // Reset values
    localparam logic       RUN_RST   = 1'b0;
    localparam logic [7:0] CTRL1_RST = 8'h00;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_CMP = 2'b00,
        MODE_CAP = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TMR = 2'b11
    } mode_t;

    // Pin-action codes per mode
    localparam logic [1:0] IO_NONE   = 2'b00;
    localparam logic [1:0] IO_LOW    = 2'b01;
    localparam logic [1:0] IO_HIGH   = 2'b10;
    localparam logic [1:0] IO_TOGGLE = 2'b11;
    localparam logic [1:0] PWM_INACT = 2'b00;
    localparam logic [1:0] PWM_ACT   = 2'b01;
    localparam logic [1:0] PWM_WAVE  = 2'b10;
    localparam logic [1:0] PWM_PULSE = 2'b11;
    localparam logic [1:0] CAP_RISE  = 2'b00;
    localparam logic [1:0] CAP_FALL  = 2'b01;
    localparam logic [1:0] CAP_BOTH  = 2'b10;
    localparam logic [1:0] CAP_OFF   = 2'b11;

    // Timer clock divider, system clocks per timer tick
    localparam int TICK_DIV_DEF = 1;

endpackage

// File: periodic_timer_unit.sv
// 10-bit periodic timer: compare, timer, PWM, single pulse, capture.
// Assumes an AHB-Lite master with pins synchronous to CLK.
//
// Functional notes
// - CCLR low: P match clears, both flags
// - CCLR high: A match clears, A flag only
// - Compare A zero: overflow at 3FF, no flag
// - Compare mode pin acts only on A match
// - Run rising sets pin to initial level
// - Timer mode counts as compare, pin unused
// - PWM: period clears counter, compare A duty
// - Period 1..1023 clocks, zero gives 1024
// - Duty at or above period: always active
// - PWM raises A and P match flags
// - PWM level, force codes and invert bit
// - Forced pin keeps PWM counting running
// - External edge sets run; rise starts pulse
// - A match or software clear ends pulse
// - Single pulse: clear only on run rise
// - Capture source pin and edge selectable
// - Capture copies counter into compare A
// - Capture: free run, P match clears, flags
// - Action 11 disables capture, counter runs
// - Capture ignores level, invert, clear bits
// - Period split into low and high byte
// - Run rise clears counter, fall holds it
// - Capture edge: rise, fall or both
module periodic_timer_unit #(
    parameter int TICK_DIV = periodic_timer_pkg::TICK_DIV_DEF
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // Timer pins
    input  wire logic        EXTERNAL_CLOCK_PIN,
    input  wire logic        CAPTURE_INPUT_PIN,
    output logic             TIMER_OUTPUT_PIN,
    output logic             TIMER_OUTPUT_EN,
    // Match flags
    output logic             MATCH_A_FLAG,
    output logic             MATCH_P_FLAG
);
    typedef struct packed {
        logic        hready;
        logic [31:0] hrdata;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic        run;
        logic [7:0]  ctrl1;
        logic [9:0]  cnt;
        logic [9:0]  cmpa;
        logic [9:0]  period;
        logic        flag_a;
        logic        flag_p;
        logic        out_level;
        logic        pin;
        logic        pin_en;
        logic        ext_prev;
        logic        src_prev;
    } state_t;

    state_t                    q;
    state_t                    next_q;
    logic                      tick;
    periodic_timer_pkg::mode_t mode;
    logic [1:0]                io;
    logic                      oc;
    logic                      pol;
    logic                      capts;
    logic                      cclr;
    logic                      take;
    logic [9:0]                cnt_inc;
    logic                      a_hit;
    logic                      p_hit;
    logic                      single;
    logic                      src;
    logic                      cap_edge;
    logic                      pwm_act;
    logic                      lvl;
    logic                      en;
    logic [31:0]               rd_mux;

    if (TICK_DIV < 1)
    begin : g_chk
        $error("periodic_timer_unit: TICK_DIV must be at least 1");
    end

    // Timer clock enable
    tick_divider #(
        .DIV   (TICK_DIV)
    ) u_div (
        .clk   (CLK),
        .rst_n (RST_N),
        .tick  (tick)
    );

    // Control fields of the live configuration
    assign mode  = periodic_timer_pkg::mode_t'(
                   q.ctrl1[periodic_timer_pkg::MODE_LSB +: 2]);
    assign io    = q.ctrl1[periodic_timer_pkg::IO_LSB +: 2];
    assign oc    = q.ctrl1[periodic_timer_pkg::OC_POS];
    assign pol   = q.ctrl1[periodic_timer_pkg::POL_POS];
    assign capts = q.ctrl1[periodic_timer_pkg::CAPTS_POS];
    assign cclr  = q.ctrl1[periodic_timer_pkg::CCLR_POS];

    // Comparators look at the value the counter is about to take
    assign cnt_inc = q.cnt + 10'h001;
    assign a_hit   = (cnt_inc == q.cmpa);
    assign p_hit   = (cnt_inc == q.period);
    assign single  = (mode == periodic_timer_pkg::MODE_PWM)
                   && (io == periodic_timer_pkg::PWM_PULSE);
    assign src     = capts ? EXTERNAL_CLOCK_PIN : CAPTURE_INPUT_PIN;
    assign take    = HSEL && HREADY && HTRANS[1];

    // Capture edge decode
    always_comb
    begin
        case (io)
            periodic_timer_pkg::CAP_RISE: cap_edge = src && !q.src_prev;
            periodic_timer_pkg::CAP_FALL: cap_edge = !src && q.src_prev;
            periodic_timer_pkg::CAP_BOTH: cap_edge = src != q.src_prev;
            default:                      cap_edge = 1'b0;
        endcase
    end

    // Read mux, sampled in the address phase
    always_comb
    begin
        rd_mux = 32'h0;
        if (HADDR[31:8] == 24'h0)
        begin
            case (HADDR[7:0])
                periodic_timer_pkg::OFF_CTRL0:
                    rd_mux[periodic_timer_pkg::RUN_POS] = q.run;
                periodic_timer_pkg::OFF_CTRL1:   rd_mux[7:0] = q.ctrl1;
                periodic_timer_pkg::OFF_CNT_LO:  rd_mux[7:0] = q.cnt[7:0];
                periodic_timer_pkg::OFF_CNT_HI:  rd_mux[1:0] = q.cnt[9:8];
                periodic_timer_pkg::OFF_CMPA_LO: rd_mux[7:0] = q.cmpa[7:0];
                periodic_timer_pkg::OFF_CMPA_HI: rd_mux[1:0] = q.cmpa[9:8];
                periodic_timer_pkg::OFF_PER_LO:  rd_mux[7:0] = q.period[7:0];
                periodic_timer_pkg::OFF_PER_HI:  rd_mux[1:0] = q.period[9:8];
                periodic_timer_pkg::OFF_FLAGS:
                    rd_mux[1:0] = {q.flag_p, q.flag_a};
                default:                         rd_mux = 32'h0;
            endcase
        end
    end

    // Next state: bus first, then hardware events so sets win
    always_comb
    begin
        next_q = q;
        lvl = 1'b0;
        en = 1'b0;
        pwm_act = 1'b0;
        next_q.hready = 1'b1;
        next_q.wr_pend = take && HWRITE && (HADDR[31:8] == 24'h0);
        next_q.wr_addr = HADDR[7:0];
        if (take && !HWRITE)
            next_q.hrdata = rd_mux;
        // Data-phase write; unmapped offsets are ignored
        if (q.wr_pend)
        begin
            case (q.wr_addr)
                periodic_timer_pkg::OFF_CTRL0:
                    next_q.run = HWDATA[periodic_timer_pkg::RUN_POS];
                periodic_timer_pkg::OFF_CTRL1:   next_q.ctrl1 = HWDATA[7:0];
                periodic_timer_pkg::OFF_CMPA_LO: next_q.cmpa[7:0] = HWDATA[7:0];
                periodic_timer_pkg::OFF_CMPA_HI: next_q.cmpa[9:8] = HWDATA[1:0];
                periodic_timer_pkg::OFF_PER_LO:
                    next_q.period[7:0] = HWDATA[7:0];
                periodic_timer_pkg::OFF_PER_HI:
                    next_q.period[9:8] = HWDATA[1:0];
                periodic_timer_pkg::OFF_FLAGS:
                begin
                    if (HWDATA[periodic_timer_pkg::FLAG_A])
                        next_q.flag_a = 1'b0;
                    if (HWDATA[periodic_timer_pkg::FLAG_P])
                        next_q.flag_p = 1'b0;
                end
                default:
                    next_q.wr_pend = next_q.wr_pend;
            endcase
        end
        // External pin edge starts a single pulse
        next_q.ext_prev = EXTERNAL_CLOCK_PIN;
        next_q.src_prev = src;
        if (single && EXTERNAL_CLOCK_PIN && !q.ext_prev)
            next_q.run = 1'b1;
        if (next_q.run && !q.run)
        begin
            next_q.cnt = periodic_timer_pkg::VAL_RST;
            if (mode == periodic_timer_pkg::MODE_CMP
                || mode == periodic_timer_pkg::MODE_PWM)
                next_q.out_level = oc;
        end
        else if (q.run && tick)
        begin
            case (mode)
                periodic_timer_pkg::MODE_CMP,
                periodic_timer_pkg::MODE_TMR:
                begin
                    if (cclr)
                    begin
                        // Zero compare A just wraps past 3FF
                        next_q.cnt = (a_hit && q.cmpa != 10'h000)
                                   ? 10'h000 : cnt_inc;
                    end
                    else
                    begin
                        next_q.cnt = p_hit ? 10'h000 : cnt_inc;
                        if (p_hit)
                            next_q.flag_p = 1'b1;
                    end
                    if (a_hit && q.cmpa != 10'h000)
                    begin
                        next_q.flag_a = 1'b1;
                        case (io)
                            periodic_timer_pkg::IO_LOW:
                                next_q.out_level = 1'b0;
                            periodic_timer_pkg::IO_HIGH:
                                next_q.out_level = 1'b1;
                            periodic_timer_pkg::IO_TOGGLE:
                                next_q.out_level = !q.out_level;
                            default:
                                next_q.out_level = q.out_level;
                        endcase
                    end
                end
                periodic_timer_pkg::MODE_PWM:
                begin
                    if (single)
                    begin
                        // Period and clear-select play no part here
                        next_q.cnt = cnt_inc;
                        if (a_hit)
                        begin
                            next_q.flag_a = 1'b1;
                            next_q.run = 1'b0;
                        end
                    end
                    else
                    begin
                        // Counting continues under forced levels
                        next_q.cnt = p_hit ? 10'h000 : cnt_inc;
                        if (a_hit)
                            next_q.flag_a = 1'b1;
                        if (p_hit)
                            next_q.flag_p = 1'b1;
                    end
                end
                default:
                begin
                    next_q.cnt = p_hit ? 10'h000 : cnt_inc;
                    if (p_hit)
                        next_q.flag_p = 1'b1;
                end
            endcase
        end
        // Capture beats a same-cycle software write of compare A
        if (mode == periodic_timer_pkg::MODE_CAP && q.run && cap_edge)
        begin
            next_q.cmpa = q.cnt;
            next_q.flag_a = 1'b1;
        end
        // Pin level from the mode
        case (mode)
            periodic_timer_pkg::MODE_CMP:
            begin
                lvl = next_q.out_level;
                en = 1'b1;
            end
            periodic_timer_pkg::MODE_PWM:
            begin
                pwm_act = (q.period != 10'h000 && q.cmpa >= q.period)
                        || (next_q.cnt < q.cmpa);
                case (io)
                    periodic_timer_pkg::PWM_INACT: lvl = !oc;
                    periodic_timer_pkg::PWM_ACT:   lvl = oc;
                    periodic_timer_pkg::PWM_WAVE:  lvl = pwm_act ~^ oc;
                    default:                       lvl = next_q.run ~^ oc;
                endcase
                en = 1'b1;
            end
            default:
            begin
                lvl = 1'b0;
                en = 1'b0;
            end
        endcase
        next_q.pin = (lvl ^ pol) && en;
        next_q.pin_en = en;
    end

    // State register
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            q <= '0;
            q.hready <= 1'b1;
            q.run <= periodic_timer_pkg::RUN_RST;
            q.ctrl1 <= periodic_timer_pkg::CTRL1_RST;
        end
        else
            q <= next_q;
    end

    // Outputs straight from flops, HRESP tied low
    assign HRDATA           = q.hrdata;
    assign HREADYOUT        = q.hready;
    assign HRESP            = 1'b0;
    assign TIMER_OUTPUT_PIN = q.pin;
    assign TIMER_OUTPUT_EN  = q.pin_en;
    assign MATCH_A_FLAG     = q.flag_a;
    assign MATCH_P_FLAG     = q.flag_p;

    // Checks on the counter and pin behaviour
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    sequence pulse_end_s;
        single && q.run && tick && a_hit;
    endsequence

    sequence pulse_done_s;
        !q.run && q.flag_a;
    endsequence

    run_rise_zero_a: assert property ($rose(q.run) |-> q.cnt == 10'h000)
        else $error("counter not cleared on run rise");
    stop_hold_a: assert property (!q.run ##1 !q.run |-> $stable(q.cnt))
        else $error("counter moved while stopped");
    init_level_a: assert property ($rose(q.run)
        && $past(mode) == periodic_timer_pkg::MODE_CMP
        |-> q.out_level == $past(oc))
        else $error("pin not at initial level");
    no_p_flag_a: assert property (cclr
        && (mode == periodic_timer_pkg::MODE_CMP
        || mode == periodic_timer_pkg::MODE_TMR)
        |=> !$rose(q.flag_p))
        else $error("P flag raised with clear on A");
    pin_unused_a: assert property (mode == periodic_timer_pkg::MODE_TMR
        |=> !TIMER_OUTPUT_EN)
        else $error("pin driven in timer mode");
    full_duty_a: assert property (mode == periodic_timer_pkg::MODE_PWM
        && io == periodic_timer_pkg::PWM_WAVE && q.period != 10'h000
        && q.cmpa >= q.period
        |=> TIMER_OUTPUT_PIN == ($past(oc) ^ $past(pol)))
        else $error("full duty not held active");
    pulse_end_a: assert property (pulse_end_s |=> pulse_done_s)
        else $error("single pulse not ended by A match");
    capture_copy_a: assert property (mode == periodic_timer_pkg::MODE_CAP
        && q.run && cap_edge
        |=> q.cmpa == $past(q.cnt) && q.flag_a)
        else $error("capture did not store counter");
    cap_off_a: assert property (mode == periodic_timer_pkg::MODE_CAP
        && io == periodic_timer_pkg::CAP_OFF && !q.wr_pend
        |=> $stable(q.cmpa))
        else $error("capture taken while disabled");
    pwm_wrap_a: assert property (mode == periodic_timer_pkg::MODE_PWM
        && !single && q.run && tick && p_hit
        |=> q.cnt == 10'h000 && q.flag_p)
        else $error("PWM period wrap wrong");
endmodule

// File: pin_source.sv
// Far-side pin model: external trigger pin and capture input pin.
// Assumes one-cycle request strobes synchronous to clk.
module pin_source #(
    parameter int HOLD = 3
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Pulse requests
    input  wire logic fire_ext,
    input  wire logic fire_cap,
    // Pins, idle low between pulses
    output logic      ext_pin,
    output logic      cap_pin
);
    int ext_left;
    int cap_left;

    // Each pulse stands HOLD cycles; longer HOLD models a slow source
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_left <= 0;
            cap_left <= 0;
        end
        else
        begin
            ext_left <= fire_ext ? HOLD : (ext_left > 0 ? ext_left - 1 : 0);
            cap_left <= fire_cap ? HOLD : (cap_left > 0 ? cap_left - 1 : 0);
        end
    end

    // Pins are plain levels
    assign ext_pin = (ext_left > 0);
    assign cap_pin = (cap_left > 0);
endmodule

// File: tb_periodic_timer_modes.sv
// Self-checking bench for the periodic timer unit over AHB-Lite.
// Assumes one slave: HREADY is fed from the unit's own HREADYOUT.
module tb_periodic_timer_modes;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 20000;

    logic        clk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic        pin;
    logic        pin_en;
    logic        ext_pin;
    logic        cap_pin;
    logic        fire_ext;
    logic        fire_cap;
    logic        flag_a;
    logic        flag_p;
    logic        hresp;
    logic [31:0] rd;
    int          miscompares;
    int          n_compared;
    int          cycles;
    int          k;

    periodic_timer_unit uut (
        .CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .EXTERNAL_CLOCK_PIN(ext_pin), .CAPTURE_INPUT_PIN(cap_pin),
        .TIMER_OUTPUT_PIN(pin), .TIMER_OUTPUT_EN(pin_en),
        .MATCH_A_FLAG(flag_a), .MATCH_P_FLAG(flag_p)
    );

    pin_source partner (
        .clk(clk), .rst_n(rst_n), .fire_ext(fire_ext),
        .fire_cap(fire_cap), .ext_pin(ext_pin), .cap_pin(cap_pin)
    );

    // Free-running system clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One single transfer; entered just after a rising edge
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        check(rd, exp);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Stop, program, clear flags, then optionally start the counter
    task automatic setup(input logic [7:0] c1, input logic [9:0] ca,
                         input logic [9:0] pr, input logic run);
        bus(periodic_timer_pkg::OFF_CTRL0, 1'b1, 32'h0);
        bus(periodic_timer_pkg::OFF_CTRL1, 1'b1, {24'h0, c1});
        bus(periodic_timer_pkg::OFF_CMPA_LO, 1'b1, {24'h0, ca[7:0]});
        bus(periodic_timer_pkg::OFF_CMPA_HI, 1'b1, {30'h0, ca[9:8]});
        bus(periodic_timer_pkg::OFF_PER_LO, 1'b1, {24'h0, pr[7:0]});
        bus(periodic_timer_pkg::OFF_PER_HI, 1'b1, {30'h0, pr[9:8]});
        bus(periodic_timer_pkg::OFF_FLAGS, 1'b1, 32'h3);
        bus(periodic_timer_pkg::OFF_CTRL0, 1'b1, {28'h0, run, 3'h0});
    endtask

    // Pin level just after the edge that started the counter
    task automatic pin_at(input logic exp);
        #1 check({31'h0, pin}, {31'h0, exp});
        @(posedge clk);
    endtask

    // High cycles of the pin over a window, sampled mid-cycle
    task automatic count_high(input int n, input int exp);
        int h;
        h = 0;
        repeat (n)
        begin
            @(negedge clk);
            h += (pin === 1'b1);
        end
        check(h, exp);
        @(posedge clk);
    endtask

    task automatic fire(input logic e);
        if (e)
            fire_ext <= 1'b1;
        else
            fire_cap <= 1'b1;
        @(posedge clk);
        fire_ext <= 1'b0;
        fire_cap <= 1'b0;
    endtask

    // Control byte: mode, action, level, invert, source, clear
    function automatic logic [7:0] c1(input logic [1:0] m, io,
                                      input logic oc, pol, cs, cc);
        return {m, io, oc, pol, cs, cc};
    endfunction

    initial
    begin
        logic [0:3] oc_t;
        int         hi_t [4];
        int         pwm_t [4];
        oc_t = 4'b1100;
        hi_t = '{10, 0, 10, 5};
        pwm_t = '{6, 2, 2, 6};
        {rst_n, hsel, hwrite, fire_ext, fire_cap} = 5'h0;
        {haddr, hwdata, htrans} = 66'h0;
        {miscompares, n_compared} = 64'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk(periodic_timer_pkg::OFF_PER_LO, 32'h0);
        rchk(periodic_timer_pkg::OFF_PER_HI, 32'h0);
        bus(periodic_timer_pkg::OFF_PER_HI, 1'b1, 32'hFF);
        rchk(periodic_timer_pkg::OFF_PER_HI, 32'h3);
        rchk(8'h40, 32'h0);
        // Compare mode, every pin action, P match clears
        for (k = 0; k < 4; k++)
        begin
            setup(c1(2'h0, k[1:0], oc_t[k], 0, 0, 0), 10'h3, 10'h5, 1);
            pin_at(oc_t[k]);
            wt(8);
            count_high(10, hi_t[k]);
            rchk(periodic_timer_pkg::OFF_FLAGS, 32'h3);
        end
        setup(c1(2'h0, 2'h2, 0, 0, 0, 1), 10'h6, 10'h2, 1);
        wt(30);
        rchk(periodic_timer_pkg::OFF_FLAGS, 32'h1);
        check({29'h0, hresp, flag_p, flag_a}, 32'h1);
        setup(c1(2'h0, 2'h2, 0, 0, 0, 0), 10'h0, 10'h0, 1);
        count_high(1100, 0);
        rchk(periodic_timer_pkg::OFF_FLAGS, 32'h2);
        setup(c1(2'h3, 2'h2, 0, 0, 0, 0), 10'h3, 10'h5, 1);
        wt(10);
        check({31'h0, pin_en}, 32'h0);
        rchk(periodic_timer_pkg::OFF_FLAGS, 32'h3);
        // PWM level and invert table, clear bit set but ignored
        for (k = 0; k < 4; k++)
        begin
            setup(c1(2'h2, 2'h2, k[0], k[1], 0, 1), 10'h1, 10'h4, 1);
            wt(4);
            count_high(8, pwm_t[k]);
        end
        setup(c1(2'h2, 2'h2, 1, 0, 0, 0), 10'h6, 10'h4, 1);
        wt(4);
        count_high(8, 8);
        setup(c1(2'h2, 2'h2, 1, 0, 0, 0), 10'h100, 10'h0, 1);
        wt(4);
        count_high(1024, 256);
        // Forced levels keep the PWM engine running
        for (k = 0; k < 2; k++)
        begin
            setup(c1(2'h2, k[1:0], 1, 0, 0, 0), 10'h1, 10'h4, 1);
            wt(4);
            count_high(8, k * 8);
            rchk(periodic_timer_pkg::OFF_FLAGS, 32'h3);
        end
        // Single pulse: action 11 kept throughout
        setup(c1(2'h2, 2'h3, 1, 0, 0, 0), 10'h5, 10'h0, 0);
        fire(1'b1);
        count_high(20, 5);
        bus(periodic_timer_pkg::OFF_CTRL0, 1'b0, 32'h0);
        check(rd & 32'h8, 32'h0);
        setup(c1(2'h2, 2'h3, 1, 0, 0, 0), 10'h200, 10'h0, 1);
        pin_at(1'b1);
        bus(periodic_timer_pkg::OFF_CTRL0, 1'b1, 32'h0);
        count_high(4, 0);
        // Capture edge kinds from the capture pin
        for (k = 0; k < 4; k++)
        begin
            setup(c1(2'h1, k[1:0], 0, 0, 0, 0), 10'h0, 10'h0, 1);
            fire(1'b0);
            wt(8);
            rchk(periodic_timer_pkg::OFF_FLAGS, {31'h0, k != 3});
        end
        setup(c1(2'h1, 2'h0, 0, 0, 1, 0), 10'h0, 10'h0, 1);
        fire(1'b0);
        wt(8);
        rchk(periodic_timer_pkg::OFF_FLAGS, 32'h0);
        fire(1'b1);
        wt(8);
        rchk(periodic_timer_pkg::OFF_FLAGS, 32'h1);
        setup(c1(2'h1, 2'h0, 0, 0, 0, 0), 10'h0, 10'h0, 1);
        wt(40);
        fire(1'b0);
        wt(8);
        bus(periodic_timer_pkg::OFF_CMPA_LO, 1'b0, 32'h0);
        check({31'h0, rd >= 40 && rd <= 48}, 32'h1);
        setup(c1(2'h1, 2'h3, 1, 1, 0, 1), 10'h0, 10'h8, 1);
        wt(20);
        rchk(periodic_timer_pkg::OFF_FLAGS, 32'h2);
        // Run fall holds the count, run rise restarts from zero
        setup(c1(2'h0, 2'h0, 0, 0, 0, 0), 10'h0, 10'h0, 1);
        wt(20);
        bus(periodic_timer_pkg::OFF_CTRL0, 1'b1, 32'h0);
        // One step per clock until the stop write lands: 22 counts
        rchk(periodic_timer_pkg::OFF_CNT_LO, 32'h16);
        wt(10);
        rchk(periodic_timer_pkg::OFF_CNT_LO, 32'h16);
        bus(periodic_timer_pkg::OFF_CTRL0, 1'b1, 32'h8);
        rchk(periodic_timer_pkg::OFF_CNT_LO, 32'h0);
        print_verdict();
    end
endmodule

// File: tick_divider.sv
// Divider giving a one-cycle timer tick every DIV system clocks.
// Assumes one clock and an asynchronous active-low reset.
module tick_divider #(
    parameter int DIV = periodic_timer_pkg::TICK_DIV_DEF
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Tick enable
    output logic      tick
);
    localparam int W = $clog2(DIV) + 1;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } div_state_t;

    div_state_t q;
    div_state_t next_q;

    if (DIV < 1)
    begin : g_chk
        $error("tick_divider: DIV must be at least 1");
    end

    // Wrap counter; tick marks the wrap
    always_comb
    begin
        next_q = q;
        next_q.tick = (q.cnt == W'(DIV - 1));
        next_q.cnt = next_q.tick ? '0 : q.cnt + W'(1);
    end

    // State register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= next_q;
    end

    assign tick = q.tick;
endmodule
